// ===== dv/adcp_cap_model.sv
// Capture side: makes conversion clock, latches words
`default_nettype none
module adcp_cap_model
    import adcp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire adcp_word_t data_out,
    output var  logic       conv_clk,
    output var  adcp_word_t word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_reg;
    // 12 clk period: each phase well over the sync need
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 4'h6;
            conv_clk <= 1'b0;
            word     <= 8'h00;
        end else begin
            cnt_reg <= (cnt_reg == 4'hB) ? 4'h0 : cnt_reg + 4'h1;
            conv_clk <= (cnt_reg == 4'hB) || (cnt_reg < 4'h5);
            if (cnt_reg == 4'hA) word <= data_out;
        end
    end
endmodule
`default_nettype wire

// ===== dv/adcp_top_asserts.sv
// Port checks for the converter pipeline
`default_nettype none
module adcp_top_asserts #(
    parameter int WORD_W = 8
) (
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              conv_clk,
    input wire logic [WORD_W-1:0] quant_step,
    input wire logic              out_en_n,
    input wire logic [WORD_W-1:0] data_out,
    input wire logic [WORD_W-1:0] data_oe_n,
    input wire logic              data_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Pin sync takes 4 clk; the data_oe_n flop shows it one later
    oe_float_a: assert property (out_en_n [*7] |-> &data_oe_n)
        else $error("bus not floated");
    oe_drive_a: assert property (!out_en_n [*7] |-> ~|data_oe_n)
        else $error("bus not driven");
    word_value_a: assert property ($changed(data_out)
        |-> data_out == $past(quant_step, 32)) else $error("bad word");
    change_rise_a: assert property ($changed(data_out)
        |-> $past(conv_clk, 3) && !$past(conv_clk, 7)) else $error("late");
    per_period_a: assert property ($rose(conv_clk) && data_valid
        |-> ##[1:8] $changed(data_out)) else $error("word missed");
    valid_rise_a: assert property ($rose(data_valid)
        |-> $past(conv_clk, 3)) else $error("valid off edge");
    cover property ($rose(data_valid));
    cover property (out_en_n ##1 !out_en_n);
    cover property ($changed(data_out) && &data_out);
endmodule
bind adcp_top adcp_top_asserts #(.WORD_W(WORD_W)) u_adcp_top_asserts (
    .clk, .nrst, .conv_clk, .quant_step, .out_en_n, .data_out, .data_oe_n,
    .data_valid);
`default_nettype wire

// ===== dv/test_adcp_top.sv
// Testbench for the converter output pipeline
`default_nettype none
module test_adcp_top
    import adcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 0, nrst = 0, out_en_n = 0, conv_clk, data_valid;
    adcp_word_t quant_step = 8'h00, data_out, data_oe_n, word;
    int         err_total, checked, cyc;
    // Neighbours differ, wrap included, so every word shows
    adcp_word_t tbl [8] = '{8'h00, 8'h01, 8'h02, 8'h7C, 8'h7D, 8'hFE,
                             8'hFF, 8'h80};
    adcp_top #(.WORD_W(8)) u_adcp_top (.clk, .nrst, .conv_clk,
        .quant_step, .out_en_n, .data_out, .data_oe_n, .data_valid);
    adcp_cap_model u_adcp_cap_model (.clk, .nrst, .data_out, .conv_clk,
        .word);
    always #25 clk = ~clk;
    task automatic check(input adcp_word_t got, input adcp_word_t exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("mismatches %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Inverse held near rises, so a rise sampler is caught
    task automatic stream(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge conv_clk);
            @(posedge clk) quant_step <= tbl[i % 8];
            @(posedge conv_clk);
            @(posedge clk) quant_step <= ~tbl[i % 8];
            if (i > 3) check(word, tbl[(i - 3) % 8]);
        end
        check({7'h00, data_valid}, 8'h01);
    endtask
    task automatic oe_test;
        repeat (30) @(posedge clk);
        out_en_n <= 1'b1;
        repeat (8) @(posedge clk);
        check(data_oe_n, 8'hFF);
        out_en_n <= 1'b0;
        repeat (8) @(posedge clk);
        check(data_oe_n, 8'h00);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        check(data_oe_n, 8'hFF);
        nrst <= 1'b1;
        fork
            stream(20);
            oe_test();
        join
        wrap_up();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            wrap_up();
        end
    end
endmodule
`default_nettype wire

// ===== rtl/adcp_cfg.svh
// Constants for the converter output pipeline
`ifndef ADCP_CFG_SVH
`define ADCP_CFG_SVH
`define ADCP_WORD_W      8
`define ADCP_LSB_POS     0
`define ADCP_MSB_POS     7
`define ADCP_RESET_WORD  8'h00
`define ADCP_CODE_MAX    8'hFF
`define ADCP_LAT_HALF    5
`define ADCP_PIPE_STAGES 2
`endif

// ===== rtl/adcp_pkg.sv
// Types shared by the converter output pipeline
`default_nettype none
`include "adcp_cfg.svh"
package adcp_pkg;
    typedef logic [`ADCP_WORD_W-1:0] adcp_word_t;
    typedef struct packed {
        logic       valid;
        adcp_word_t code;
    } adcp_samp_t;
    typedef struct packed {
        adcp_word_t data_out;
        adcp_word_t data_oe_n;
    } adcp_bus_t;
endpackage
`default_nettype wire

// ===== rtl/adcp_stage.sv
// One pipeline stage of the conversion path
`default_nettype none
`include "adcp_cfg.svh"
module adcp_stage
    import adcp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       en,
    input  wire adcp_samp_t d,
    output var  adcp_samp_t q
);
    adcp_samp_t q_reg;

    // Advance one word per enabled edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_reg <= '{valid: 1'b0, code: `ADCP_RESET_WORD};
        end else if (en) begin
            q_reg <= d;
        end
    end

    assign q = q_reg;
endmodule
`default_nettype wire

// ===== rtl/adcp_top.sv
// Converter digital side: sample, pipeline, and drive the result bus
//
// Functional notes
// RULE_01: Take a new sample at each falling edge of the conversion clock.
// RULE_02: Word appears 2.5 clocks after its sample, changing on a rise.
// RULE_03: Output enable low drives the bus; high floats every data bit.
// RULE_04: Result is 8 bits parallel, bit 0 least, bit 7 most significant.
// RULE_05: Code is straight binary step index, zero up to all ones.
// RULE_06: One new word each clock; capture latches one per rising edge.
`default_nettype none
`include "adcp_cfg.svh"
module adcp_top
    import adcp_pkg::*;
#(
    parameter int WORD_W = `ADCP_WORD_W
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              conv_clk,
    input  wire logic [WORD_W-1:0] quant_step,
    input  wire logic              out_en_n,
    output logic [WORD_W-1:0]      data_out,
    output logic [WORD_W-1:0]      data_oe_n,
    output logic                   data_valid
);
    // Pin inputs through three flops; second and third must agree
    logic [2:0]        cclk_sync_reg;
    logic [2:0]        oe_sync_reg;
    logic              cclk_lvl_reg;
    logic              oe_n_lvl_reg;
    logic [WORD_W-1:0] step_hold_reg;
    logic [WORD_W-1:0] step_s1_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cclk_sync_reg <= 3'h0;
            oe_sync_reg   <= 3'h7;
        end else begin
            cclk_sync_reg <= {cclk_sync_reg[1:0], conv_clk};
            oe_sync_reg   <= {oe_sync_reg[1:0], out_en_n};
        end
    end

    // A level counts only once two late flops agree, filtering one glitch
    wire cclk_agree = cclk_sync_reg[1] == cclk_sync_reg[2];
    wire oe_agree   = oe_sync_reg[1] == oe_sync_reg[2];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cclk_lvl_reg <= 1'b0;
            oe_n_lvl_reg <= 1'b1;
        end else begin
            if (cclk_agree) cclk_lvl_reg <= cclk_sync_reg[2];
            if (oe_agree)   oe_n_lvl_reg <= oe_sync_reg[2];
        end
    end

    // Edges of the filtered conversion clock
    wire cclk_next = cclk_agree ? cclk_sync_reg[2] : cclk_lvl_reg;
    wire fall_evt  = cclk_lvl_reg & ~cclk_next;
    wire rise_evt  = ~cclk_lvl_reg & cclk_next;

    // The analog quantiser hands a step index; hold it a cycle so it
    // has settled by the sampling edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            step_s1_reg   <= `ADCP_RESET_WORD;
            step_hold_reg <= `ADCP_RESET_WORD;
        end else begin
            step_s1_reg   <= quant_step;
            if (fall_evt) step_hold_reg <= step_s1_reg; // RULE_01
        end
    end

    // Sampled word; code is the step index untouched, MSB at top
    adcp_samp_t samp;
    assign samp.valid = 1'b1;
    assign samp.code  = step_hold_reg[`ADCP_MSB_POS:`ADCP_LSB_POS]; // RULE_05

    // Sample on fall, then two rises in the pipe: third rise is 2.5 clocks
    adcp_samp_t pipe [0:`ADCP_PIPE_STAGES];
    logic       smp_pend_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            smp_pend_reg <= 1'b0;
        end else if (fall_evt) begin
            smp_pend_reg <= 1'b1;
        end
    end

    assign pipe[0] = smp_pend_reg ? samp : '{valid: 1'b0, code: '0};

    genvar gi;
    generate
        for (gi = 0; gi < `ADCP_PIPE_STAGES; gi++) begin : g_pipe
            adcp_stage u_stage (
                .clk  (clk),
                .nrst (nrst),
                .en   (rise_evt),   // RULE_06
                .d    (pipe[gi]),
                .q    (pipe[gi+1])
            );
        end
    endgenerate

    // Data and valid flops update only on a conversion-clock rise; the enable flops every clock
    adcp_bus_t bus_reg;
    logic      valid_reg;
    wire       oe_drive = ~oe_n_lvl_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_reg   <= '{data_out: `ADCP_RESET_WORD, data_oe_n: '1};
            valid_reg <= 1'b0;
        end else begin
            if (rise_evt) begin
                bus_reg.data_out <= pipe[`ADCP_PIPE_STAGES].code; // RULE_02
                valid_reg        <= pipe[`ADCP_PIPE_STAGES].valid;
            end
            bus_reg.data_oe_n <= {WORD_W{~oe_drive}}; // RULE_03
        end
    end

    // Bit 0 is the least significant result bit
    assign data_out   = bus_reg.data_out; // RULE_04
    assign data_oe_n  = bus_reg.data_oe_n;
    assign data_valid = valid_reg;
endmodule
`default_nettype wire
